/* File: logic/fb_divide_check.sv */
// Feedback division value and legality of the A and B pair
`timescale 1ns/1ps
`default_nettype none
module fb_divide_check
   import opll_ctrl_pkg::*;
(
   input wire logic [7:0] divWord,
   output logic [7:0] divideValue,
   output logic divideLegal
);
   logic [1:0] aCount; // A count
   logic [5:0] bCount; // B count

   assign aCount = divWord[FB_A_HI:FB_A_LO];
   assign bCount = divWord[FB_B_HI:FB_B_LO];
   // Four times B plus A; max 255 so eight bits suffice
   assign divideValue = {bCount, 2'h0} + {6'h00, aCount};

   // Allowed pairs; flagged only, the word is still used as written
   always_comb begin
      case (bCount)
         B_MIN: divideLegal = (aCount == 2'h0);
         6'h04: divideLegal = (aCount <= 2'h1);
         6'h05, 6'h06: divideLegal = (aCount <= 2'h2);
         default: divideLegal = (bCount >= B_FREE);
      endcase
   end
endmodule : fb_divide_check
`default_nettype wire

/* File: logic/opll_ctrl_pkg.sv */
// Constants for the output loop control register bank
package opll_ctrl_pkg;
   // Register port geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   // Register offsets
   localparam logic [11:0] FB_DIV_ADDR = 12'h0f1;
   localparam logic [11:0] LOOP_CTRL_ADDR = 12'h0f2;
   localparam logic [11:0] OSC_CTRL_ADDR = 12'h0f3;
   // Feedback divider fields
   localparam int FB_A_HI = 7;
   localparam int FB_A_LO = 6;
   localparam int FB_B_HI = 5;
   localparam int FB_B_LO = 0;
   // Loop control fields
   localparam int LC_LD_PD = 7;
   localparam int LC_RSVD = 6;
   localparam int LC_DOUBLER = 5;
   localparam int LC_ABL_OVR = 4;
   localparam int LC_ABL_HI = 3;
   localparam int LC_ABL_LO = 2;
   localparam int LC_PUMP_HI = 1;
   localparam int LC_PUMP_LO = 0;
   // Oscillator control fields
   localparam int OC_FORCE_SYNC = 4;
   localparam int OC_REF_VALID = 3;
   localparam int OC_MIDSCALE = 2;
   localparam int OC_CAL = 1;
   // Bits of the oscillator control register that hold state
   localparam logic [7:0] OC_USED_MASK = 8'h1e;
   // Reset values
   localparam logic [7:0] FB_DIV_RESET = 8'h07;
   localparam logic [7:0] LOOP_CTRL_RESET = 8'h0b;
   localparam logic [7:0] OSC_CTRL_RESET = 8'h00;
   // Antibacklash width codes
   localparam logic [1:0] ABL_MIN = 2'h0;
   localparam logic [1:0] ABL_LOW = 2'h1;
   localparam logic [1:0] ABL_HIGH = 2'h2;
   localparam logic [1:0] ABL_MAX = 2'h3;
   // Width used when the device picks the period itself
   localparam logic [1:0] ABL_AUTO = ABL_HIGH;
   // Charge pump mode codes
   localparam logic [1:0] PUMP_TRISTATE = 2'h0;
   localparam logic [1:0] PUMP_UP = 2'h1;
   localparam logic [1:0] PUMP_DOWN = 2'h2;
   localparam logic [1:0] PUMP_NORMAL = 2'h3;
   // Divider legality limits
   localparam logic [5:0] B_MIN = 6'h03;
   localparam logic [5:0] B_FREE = 6'h07;
   // Distribution sync states
   typedef enum logic [2:0] {
      SYNC_HOLD = 3'b001,
      SYNC_ALIGN = 3'b010,
      SYNC_RUN = 3'b100
   } sync_state_t;
   // Calibration states
   typedef enum logic [2:0] {
      CAL_IDLE = 3'b001,
      CAL_RUN = 3'b010,
      CAL_DONE = 3'b100
   } cal_state_t;
endpackage : opll_ctrl_pkg

/* File: logic/output_pll_control_registers.sv */
// Output loop control register bank with sync release and calibration
`timescale 1ns/1ps
`default_nettype none
module output_pll_control_registers (
   input wire logic clk,
   input wire logic reset,
   // Register port from the serial control port
   input wire logic [opll_ctrl_pkg::ADDR_W-1:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [opll_ctrl_pkg::DATA_W-1:0] regWriteData,
   output logic [opll_ctrl_pkg::DATA_W-1:0] regReadData,
   // Indicators from the analogue side, asynchronous
   input wire logic loopLockPin,
   input wire logic refOscOkPin,
   input wire logic calDonePin,
   // Controls to the analogue side
   output logic [7:0] feedbackDivide,
   output logic divideLegal,
   output logic lockDetectPowerDown,
   output logic doublerEnable,
   output logic [1:0] antibacklashWidth,
   output logic [1:0] pumpMode,
   output logic refValid,
   output logic vcoMidscale,
   output logic distSyncHold,
   output logic distAlignPulse,
   output logic calStartPulse,
   output logic calReset,
   output logic calBusy
);
   import opll_ctrl_pkg::*;
   // Properties sample on clk and rest while reset is high
   default clocking assertClk @(posedge clk);
   endclocking
   default disable iff (reset);

   logic [7:0] fbDivQ; // Feedback divider word
   logic [7:0] loopCtrlQ; // Loop control word
   logic [7:0] oscCtrlQ; // Oscillator control word
   logic lockSync; // Filtered lock indicator
   logic refOkSync; // Filtered reference oscillator indicator
   logic calDoneSync; // Filtered calibration done
   logic [7:0] divValueD; // Combinational division value
   logic divLegalD; // Combinational legality
   logic lockSeen; // Lock usable: detector powered and locked
   logic calBitPrevQ; // Calibration bit one cycle earlier
   sync_state_t syncStateQ; // Distribution sync state
   cal_state_t calStateQ; // Calibration state
   logic wrFb; // Write strobe for divider word
   logic wrLoop; // Write strobe for loop control
   logic wrOsc; // Write strobe for oscillator control

   // Address decode
   assign wrFb = regWrite && (regAddr == FB_DIV_ADDR);
   assign wrLoop = regWrite && (regAddr == LOOP_CTRL_ADDR);
   assign wrOsc = regWrite && (regAddr == OSC_CTRL_ADDR);

   // Pin synchronisers
   pin_sync lockSyncU (
      .clk(clk),
      .reset(reset),
      .pinIn(loopLockPin),
      .pinOut(lockSync)
   );
   pin_sync refOkSyncU (
      .clk(clk),
      .reset(reset),
      .pinIn(refOscOkPin),
      .pinOut(refOkSync)
   );
   pin_sync calDoneSyncU (
      .clk(clk),
      .reset(reset),
      .pinIn(calDonePin),
      .pinOut(calDoneSync)
   );

   // Division value and legality
   fb_divide_check divCheckU (
      .divWord(fbDivQ),
      .divideValue(divValueD),
      .divideLegal(divLegalD)
   );

   // Divider word storage
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         fbDivQ <= FB_DIV_RESET;
      end else if (wrFb) begin
         fbDivQ <= regWriteData;
      end
   end

   // Loop control storage; reserved bit stored as written
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loopCtrlQ <= LOOP_CTRL_RESET;
      end else if (wrLoop) begin
         loopCtrlQ <= regWriteData;
      end
   end

   // Oscillator control storage; reserved bits never held
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         oscCtrlQ <= OSC_CTRL_RESET;
      end else if (wrOsc) begin
         oscCtrlQ <= regWriteData & OC_USED_MASK;
      end
   end

   // Read port; unmapped offsets read zero
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         regReadData <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            FB_DIV_ADDR: regReadData <= fbDivQ;
            LOOP_CTRL_ADDR: regReadData <= loopCtrlQ;
            OSC_CTRL_ADDR: regReadData <= oscCtrlQ;
            default: regReadData <= 8'h00;
         endcase
      end
   end

   // Divider outputs, registered one cycle after the word
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         feedbackDivide <= 8'h00;
         divideLegal <= 1'b0;
      end else begin
         feedbackDivide <= divValueD;
         divideLegal <= divLegalD;
      end
   end

   // Loop control outputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         lockDetectPowerDown <= 1'b0;
         doublerEnable <= 1'b0;
         antibacklashWidth <= ABL_AUTO;
         pumpMode <= PUMP_NORMAL;
      end else begin
         lockDetectPowerDown <= loopCtrlQ[LC_LD_PD];
         doublerEnable <= loopCtrlQ[LC_DOUBLER];
         // Programmed width only counts under override
         if (loopCtrlQ[LC_ABL_OVR]) begin
            antibacklashWidth <= loopCtrlQ[LC_ABL_HI:LC_ABL_LO];
         end else begin
            antibacklashWidth <= ABL_AUTO;
         end
         pumpMode <= loopCtrlQ[LC_PUMP_HI:LC_PUMP_LO];
      end
   end

   // Oscillator control outputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         refValid <= 1'b0;
         vcoMidscale <= 1'b0;
      end else begin
         refValid <= refOkSync || oscCtrlQ[OC_REF_VALID];
         vcoMidscale <= oscCtrlQ[OC_MIDSCALE];
      end
   end

   // A powered-down detector cannot report lock
   assign lockSeen = lockSync && !loopCtrlQ[LC_LD_PD];

   // Distribution sync: hold, one align pulse, then run.
   // Once released it stays released; a later loss of lock
   // does not re-freeze outputs that are already aligned.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         syncStateQ <= SYNC_HOLD;
      end else begin
         case (syncStateQ)
            SYNC_HOLD: begin
               if (lockSeen || oscCtrlQ[OC_FORCE_SYNC]) begin
                  syncStateQ <= SYNC_ALIGN;
               end
            end
            SYNC_ALIGN: syncStateQ <= SYNC_RUN;
            SYNC_RUN: syncStateQ <= SYNC_RUN;
            default: syncStateQ <= SYNC_HOLD;
         endcase
      end
   end

   // Sync outputs follow the state one cycle later
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         distSyncHold <= 1'b1;
         distAlignPulse <= 1'b0;
      end else begin
         distSyncHold <= (syncStateQ != SYNC_RUN);
         distAlignPulse <= (syncStateQ == SYNC_ALIGN);
      end
   end

   // Edge memory of the calibration bit
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         calBitPrevQ <= 1'b0;
      end else begin
         calBitPrevQ <= oscCtrlQ[OC_CAL];
      end
   end

   // Calibration: start on a rising bit, zero returns to idle.
   // The bit never clears itself, so a rerun needs 0 then 1.
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         calStateQ <= CAL_IDLE;
      end else if (!oscCtrlQ[OC_CAL]) begin
         calStateQ <= CAL_IDLE;
      end else begin
         case (calStateQ)
            CAL_IDLE: begin
               if (!calBitPrevQ) begin
                  calStateQ <= CAL_RUN;
               end
            end
            CAL_RUN: begin
               if (calDoneSync) begin
                  calStateQ <= CAL_DONE;
               end
            end
            CAL_DONE: calStateQ <= CAL_DONE;
            default: calStateQ <= CAL_IDLE;
         endcase
      end
   end

   // Calibration outputs
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         calStartPulse <= 1'b0;
         calReset <= 1'b1;
         calBusy <= 1'b0;
      end else begin
         calStartPulse <= oscCtrlQ[OC_CAL] && !calBitPrevQ;
         calReset <= !oscCtrlQ[OC_CAL];
         calBusy <= (calStateQ == CAL_RUN);
      end
   end

   // Align pulse while still held, then released and free running
   sequence releaseSeq;
      distAlignPulse && distSyncHold ##1 !distSyncHold && !distAlignPulse;
   endsequence

   // Calibration bit rises: start pulse then reset stays low
   sequence calStartSeq;
      calStartPulse && !calReset ##1 !calStartPulse && !calReset;
   endsequence

   AST_DIV_VALUE: assert property (
      wrFb |=> ##1 feedbackDivide ==
         ({$past(regWriteData[FB_B_HI:FB_B_LO], 2), 2'h0}
          + {6'h00, $past(regWriteData[FB_A_HI:FB_A_LO], 2)}))
      else $error("feedback division not four B plus A");

   AST_DIV_LEGAL: assert property (
      wrFb && regWriteData == 8'h43 |=> ##1 !divideLegal)
      else $error("illegal A and B pair flagged legal");

   AST_LD_PD: assert property (
      wrLoop |=> ##1 lockDetectPowerDown == $past(regWriteData[LC_LD_PD], 2))
      else $error("lock detector power down does not follow bit 7");

   AST_DOUBLER: assert property (
      wrLoop |=> ##1 doublerEnable == $past(regWriteData[LC_DOUBLER], 2))
      else $error("doubler enable does not follow bit 5");

   AST_ABL_AUTO: assert property (
      !loopCtrlQ[LC_ABL_OVR] |=> antibacklashWidth == ABL_HIGH)
      else $error("automatic antibacklash not at high width");

   AST_ABL_MAN: assert property (
      loopCtrlQ[LC_ABL_OVR] |=> antibacklashWidth ==
         $past(loopCtrlQ[LC_ABL_HI:LC_ABL_LO]))
      else $error("programmed antibacklash width not applied");

   AST_PUMP: assert property (
      wrLoop |=> ##1 pumpMode ==
         $past(regWriteData[LC_PUMP_HI:LC_PUMP_LO], 2))
      else $error("pump mode does not follow written field");

   AST_SYNC_HOLD: assert property (
      syncStateQ == SYNC_HOLD && !lockSeen && !oscCtrlQ[OC_FORCE_SYNC]
      |=> ##1 distSyncHold)
      else $error("distribution released without lock or force");

   AST_SYNC_FORCE: assert property (
      syncStateQ == SYNC_HOLD && oscCtrlQ[OC_FORCE_SYNC] |=> ##1 releaseSeq)
      else $error("forced sync release did not align and run");

   AST_REF_VALID: assert property (
      oscCtrlQ[OC_REF_VALID] |=> refValid)
      else $error("reference not valid under override");

   AST_MIDSCALE: assert property (
      wrOsc |=> ##1 vcoMidscale == $past(regWriteData[OC_MIDSCALE], 2))
      else $error("midscale force does not follow bit 2");

   AST_CAL_START: assert property (
      $rose(oscCtrlQ[OC_CAL]) |=> calStartSeq)
      else $error("calibration start pulse missing or too long");

   AST_CAL_RESET: assert property (
      wrOsc && !regWriteData[OC_CAL]
      |=> ##1 calReset && calStateQ == CAL_IDLE)
      else $error("writing zero did not reset calibration");
endmodule : output_pll_control_registers
`default_nettype wire

/* File: logic/pin_sync.sv */
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic pinIn,
   output logic pinOut
);
   logic s1Q; // First stage, read by s2Q only
   logic s2Q; // Second stage
   logic s3Q; // Third stage

   // Shift chain; metastability settles in the first stage
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         s1Q <= 1'b0;
         s2Q <= 1'b0;
         s3Q <= 1'b0;
      end else begin
         s1Q <= pinIn;
         s2Q <= s1Q;
         s3Q <= s2Q;
      end
   end

   // Accept a change only once two stages agree
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pinOut <= 1'b0;
      end else if (s2Q == s3Q) begin
         pinOut <= s3Q;
      end
   end
endmodule : pin_sync
`default_nettype wire

/* File: tb/test_output_pll_control_registers.sv */
// Self-checking bench for the output loop control register bank
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, expv, gotv) \
   begin \
      comparisons++; \
      if ((gotv) !== (expv)) begin \
         $display("mismatch %s expected %h seen %h", what, expv, gotv); \
         errTotal++; \
      end \
   end
module test_output_pll_control_registers;
   import opll_ctrl_pkg::*;
   logic clk, reset; // Bench clock and reset
   logic [ADDR_W-1:0] regAddr;
   logic regWrite, regRead;
   logic [DATA_W-1:0] regWriteData, regReadData;
   logic loopLockPin, refOscOkPin, calDonePin; // Analogue indicators
   logic [7:0] feedbackDivide;
   logic divideLegal, lockDetectPowerDown, doublerEnable;
   logic [1:0] antibacklashWidth, pumpMode;
   logic refValid, vcoMidscale, distSyncHold, distAlignPulse;
   logic calStartPulse, calReset, calBusy;
   int errTotal = 0; // Mismatches seen
   int comparisons = 0; // Checks made

   output_pll_control_registers output_pll_control_registers_i (
      .clk(clk), .reset(reset), .regAddr(regAddr), .regWrite(regWrite),
      .regRead(regRead), .regWriteData(regWriteData),
      .regReadData(regReadData), .loopLockPin(loopLockPin),
      .refOscOkPin(refOscOkPin), .calDonePin(calDonePin),
      .feedbackDivide(feedbackDivide), .divideLegal(divideLegal),
      .lockDetectPowerDown(lockDetectPowerDown),
      .doublerEnable(doublerEnable), .antibacklashWidth(antibacklashWidth),
      .pumpMode(pumpMode), .refValid(refValid), .vcoMidscale(vcoMidscale),
      .distSyncHold(distSyncHold), .distAlignPulse(distAlignPulse),
      .calStartPulse(calStartPulse), .calReset(calReset), .calBusy(calBusy)
   );

   // 10 MHz clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Verdict and end of run, shared with the watchdog
   task automatic endSim();
      if (errTotal == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : endSim

   // One-cycle write strobe, driven off the falling edge
   task automatic regWr(input logic [11:0] a, input logic [7:0] d);
      @(negedge clk);
      regAddr = a;
      regWriteData = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
   endtask : regWr

   // One-cycle read strobe; data lands on the taking edge
   task automatic regRdCheck(input logic [11:0] a, input logic [7:0] e);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      `CHECK("regReadData", e, regReadData)
   endtask : regRdCheck

   // Let n rising edges land, then sample at the falling edge
   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : settle

   // Mid-run reset, pins back to idle
   task automatic doReset();
      @(negedge clk);
      reset = 1'b1;
      loopLockPin = 1'b0;
      refOscOkPin = 1'b0;
      calDonePin = 1'b0;
      repeat (2) @(negedge clk);
      reset = 1'b0;
   endtask : doReset

   // Reset values of registers and outputs
   task automatic testResetValues();
      `CHECK("feedbackDivide", 8'h1c, feedbackDivide)
      `CHECK("divideLegal", 1'b1, divideLegal)
      `CHECK("lockDetectPowerDown", 1'b0, lockDetectPowerDown)
      `CHECK("doublerEnable", 1'b0, doublerEnable)
      `CHECK("antibacklashWidth", ABL_HIGH, antibacklashWidth)
      `CHECK("pumpMode", PUMP_NORMAL, pumpMode)
      `CHECK("distSyncHold", 1'b1, distSyncHold)
      `CHECK("vcoMidscale", 1'b0, vcoMidscale)
      `CHECK("calReset", 1'b1, calReset)
      regRdCheck(FB_DIV_ADDR, 8'h07);
      regRdCheck(LOOP_CTRL_ADDR, 8'h0b);
      regRdCheck(OSC_CTRL_ADDR, 8'h00);
   endtask : testResetValues

   // Divider value and the allowed A and B pairs at their edges
   task automatic testDivider();
      logic [7:0] w [10] = '{8'h03, 8'h43, 8'h44, 8'h84, 8'h85, 8'hc6,
         8'hc7, 8'h02, 8'hff, 8'h86};
      // Four B plus A, worked out by hand for each word
      logic [7:0] n [10] = '{8'h0c, 8'h0d, 8'h11, 8'h12, 8'h16, 8'h1b,
         8'h1f, 8'h08, 8'hff, 8'h1a};
      logic ok [10] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
         1'b1, 1'b1};
      for (int i = 0; i < 10; i++) begin
         regWr(FB_DIV_ADDR, w[i]);
         settle(2);
         `CHECK("feedbackDivide", n[i], feedbackDivide)
         `CHECK("divideLegal", ok[i], divideLegal)
         regRdCheck(FB_DIV_ADDR, w[i]);
      end
   endtask : testDivider

   // Every width and pump code under the override, then code 0 without it
   task automatic testLoopControl();
      logic [7:0] w;
      for (int i = 0; i < 4; i++) begin
         w = {i[0], 1'b0, i[1], 1'b1, i[1:0], ~i[1:0]};
         regWr(LOOP_CTRL_ADDR, w);
         settle(2);
         `CHECK("lockDetectPowerDown", i[0], lockDetectPowerDown)
         `CHECK("doublerEnable", i[1], doublerEnable)
         `CHECK("antibacklashWidth", i[1:0], antibacklashWidth)
         `CHECK("pumpMode", ~i[1:0], pumpMode)
         regRdCheck(LOOP_CTRL_ADDR, w);
      end
      // Programmed code ignored while the override is clear
      regWr(LOOP_CTRL_ADDR, 8'h00);
      settle(2);
      `CHECK("antibacklashWidth", ABL_HIGH, antibacklashWidth)
      `CHECK("pumpMode", PUMP_TRISTATE, pumpMode)
      // Unmapped places: writes dropped, reads zero
      regWr(12'h0f4, 8'hff);
      regWr(12'h1f2, 8'hff);
      regRdCheck(12'h0f4, 8'h00);
      regRdCheck(12'h1f2, 8'h00);
      regRdCheck(LOOP_CTRL_ADDR, 8'h00);
   endtask : testLoopControl

   // Lock ignored while detector is off, then released once
   task automatic testLockRelease();
      int pulses;
      pulses = 0;
      doReset();
      regWr(LOOP_CTRL_ADDR, 8'h8b);
      loopLockPin = 1'b1;
      settle(12);
      `CHECK("distSyncHold", 1'b1, distSyncHold)
      regWr(LOOP_CTRL_ADDR, 8'h0b);
      for (int i = 0; i < 14 && distSyncHold !== 1'b0; i++) begin
         @(negedge clk);
         if (distAlignPulse === 1'b1) pulses++;
      end
      `CHECK("distSyncHold", 1'b0, distSyncHold)
      `CHECK("alignPulses", 1, pulses)
   endtask : testLockRelease

   // Forced release without lock, reference valid, midscale
   task automatic testOscillator();
      doReset();
      // Write edge, then align state, then the pulse shows
      regWr(OSC_CTRL_ADDR, 8'h10);
      settle(2);
      `CHECK("distAlignPulse", 1'b1, distAlignPulse)
      `CHECK("distSyncHold", 1'b1, distSyncHold)
      @(negedge clk);
      `CHECK("distAlignPulse", 1'b0, distAlignPulse)
      `CHECK("distSyncHold", 1'b0, distSyncHold)
      `CHECK("refValid", 1'b0, refValid)
      regWr(OSC_CTRL_ADDR, 8'h0c);
      settle(2);
      `CHECK("refValid", 1'b1, refValid)
      `CHECK("vcoMidscale", 1'b1, vcoMidscale)
      regWr(OSC_CTRL_ADDR, 8'h00);
      settle(2);
      `CHECK("refValid", 1'b0, refValid)
      `CHECK("vcoMidscale", 1'b0, vcoMidscale)
      refOscOkPin = 1'b1;
      settle(7);
      `CHECK("refValid", 1'b1, refValid)
      // Unused bits never stored
      regWr(OSC_CTRL_ADDR, 8'hf1);
      regRdCheck(OSC_CTRL_ADDR, 8'h10);
   endtask : testOscillator

   // Start, hold, no restart on rewrite, reset by zero, restart
   task automatic testCalibration();
      int starts;
      starts = 0;
      doReset();
      // The start pulse stands for the one cycle after the write
      regWr(OSC_CTRL_ADDR, 8'h02);
      settle(1);
      `CHECK("calStartPulse", 1'b1, calStartPulse)
      `CHECK("calReset", 1'b0, calReset)
      @(negedge clk);
      `CHECK("calBusy", 1'b1, calBusy)
      calDonePin = 1'b1;
      for (int i = 0; i < 10 && calBusy !== 1'b0; i++) @(negedge clk);
      `CHECK("calBusy", 1'b0, calBusy)
      regRdCheck(OSC_CTRL_ADDR, 8'h02);
      regWr(OSC_CTRL_ADDR, 8'h02);
      repeat (5) begin
         @(negedge clk);
         if (calStartPulse === 1'b1) starts++;
      end
      `CHECK("calStarts", 0, starts)
      calDonePin = 1'b0;
      regWr(OSC_CTRL_ADDR, 8'h00);
      settle(2);
      `CHECK("calReset", 1'b1, calReset)
      regWr(OSC_CTRL_ADDR, 8'h02);
      settle(1);
      `CHECK("calStartPulse", 1'b1, calStartPulse)
   endtask : testCalibration

   // Cuts a hang short
   initial begin
      repeat (4000) @(posedge clk);
      errTotal++;
      endSim();
   end

   // Main sequence
   initial begin
      reset = 1'b1;
      regAddr = '0;
      regWrite = 1'b0;
      regRead = 1'b0;
      regWriteData = '0;
      loopLockPin = 1'b0;
      refOscOkPin = 1'b0;
      calDonePin = 1'b0;
      repeat (16) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      settle(1);
      testResetValues();
      testDivider();
      testLoopControl();
      testLockRelease();
      testOscillator();
      testCalibration();
      endSim();
   end
endmodule : test_output_pll_control_registers
`default_nettype wire
